// ---- rtl/tsp_dev_port.sv ----
// device end: power-on reset, i2c and spi register access slave
// Operation
// RQ1: internal reset releases itself after fixed interval
// RQ2: irq high in reset, falls at release
// RQ3: sensor results undefined during power-on reset
// RQ4: i2c write: address, index, data, auto-increment
// RQ5: i2c read: repeated start, incrementing reads, nack ends
// RQ6: strap pin selects address 0x16 or 0x17
// RQ7: spi modes 0 and 3, rise in fall out
// RQ8: spi write stores incrementing indices while selected
// RQ9: spi read shifts incrementing indices while selected
// RQ10: i2c after init; select fall switches spi
// RQ11: irq rises when a measurement completes
// RQ12: external reset low holds reset, pins released
// RQ13: spi first byte is command, msb first
// RQ14: spi data out driven only during read
`timescale 1ns/1ns
module tsp_dev_port
  import tsp_pkg::*;
#(
  parameter int POR_CYC = POR_CYCLES
)(
  input  wire logic          clk,
  input  wire logic          rst,
  tsp_link_if.dev            link,
  input  wire logic          external_reset_n,
  input  wire logic          meas_done,
  input  wire logic [DW-1:0] reg_rdata,
  output logic      [7:0]    reg_addr,
  output logic      [DW-1:0] reg_wdata,
  output logic               reg_wr,
  output logic               core_rst,
  output logic               spi_mode,
  input  wire logic [7:0]    touch_in,
  input  wire logic          error_in,
  output logic      [7:0]    touch_o,
  output logic               touch_oe,
  output logic               error_o,
  output logic               error_oe
);
  localparam int PW = $clog2(POR_CYC + 1);

  // ==========================================================
  // pin synchronisers
  logic [NPIN-1:0] s1_q, s2_q, s3_q;
  logic [NPIN-1:0] pins;
  assign pins = {external_reset_n, link.strap_so, link.chip_select_n, link.sda, link.scl};

  always_ff @(posedge clk) begin
    s1_q <= pins;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  logic scl_rise, scl_fall, sda_fall, sda_rise, cs_fall, cs_n, sda_in;
  assign scl_rise = s2_q[P_SCL] & ~s3_q[P_SCL];
  assign scl_fall = ~s2_q[P_SCL] & s3_q[P_SCL];
  assign sda_fall = ~s2_q[P_SDA] & s3_q[P_SDA];
  assign sda_rise = s2_q[P_SDA] & ~s3_q[P_SDA];
  assign cs_fall  = ~s2_q[P_CS] & s3_q[P_CS];
  assign cs_n     = s2_q[P_CS];
  assign sda_in   = s2_q[P_SDA];

  // ==========================================================
  // power-on reset, mode select, interrupt, pin gating
  logic [PW-1:0] por_cnt_q, por_cnt_d;
  logic          por_q, por_d, spi_q, spi_d, irq_q, irq_d, host_begin;
  logic [7:0]    touch_q, touch_d;
  logic          touch_oe_q, err_q, err_d;

  always_comb begin
    por_cnt_d = por_cnt_q;
    por_d     = por_q;
    if (!s2_q[P_XRST]) begin
      por_cnt_d = '0;                                   // RQ12
      por_d     = 1'h1;                                 // RQ12
    end else if (por_q) begin
      if (por_cnt_q == PW'(POR_CYC - 1)) begin
        por_d = 1'h0;                                   // RQ1
      end else begin
        por_cnt_d = por_cnt_q + 1'h1;                   // RQ1
      end
    end
    spi_d = spi_q;
    if (por_q) begin
      spi_d = 1'h0;                                     // RQ10
    end else if (cs_fall) begin
      spi_d = 1'h1;                                     // RQ10
    end
    irq_d = irq_q;
    if (por_d) begin
      irq_d = 1'h1;                                     // RQ2
    end else if (por_q) begin
      irq_d = 1'h0;                                     // RQ2
    end else if (meas_done) begin
      irq_d = 1'h1;                                     // RQ11
    end else if (host_begin) begin
      irq_d = 1'h0;
    end
    // results are only passed on once reset is gone
    touch_d = por_q ? '0 : touch_in;                    // RQ3
    err_d   = por_q ? 1'h0 : error_in;                  // RQ3
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      por_cnt_q  <= '0;
      por_q      <= 1'h1;
      spi_q      <= 1'h0;
      irq_q      <= 1'h1;
      touch_q    <= '0;
      err_q      <= 1'h0;
      touch_oe_q <= 1'h0;
    end else begin
      por_cnt_q  <= por_cnt_d;
      por_q      <= por_d;
      spi_q      <= spi_d;
      irq_q      <= irq_d;
      touch_q    <= touch_d;
      err_q      <= err_d;
      touch_oe_q <= ~por_d;                             // RQ12
    end
  end

  // ==========================================================
  // serial protocol engine
  tsp_dev_st_t st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d, tx_q, tx_d, idx_q, idx_d, wdata_q, wdata_d, rx_byte;
  logic        rw_q, rw_d, ack_q, ack_d, sda_oe_q, sda_oe_d, so_q, so_d, so_oe_q, so_oe_d;
  logic        wr_q, wr_d;
  logic [6:0]  my_addr;

  assign my_addr = s2_q[P_STRAP] ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;  // RQ6
  assign rx_byte = {sh_q[6:0], sda_in};

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    sh_d       = sh_q;
    tx_d       = tx_q;
    idx_d      = idx_q;
    wdata_d    = wdata_q;
    rw_d       = rw_q;
    ack_d      = ack_q;
    sda_oe_d   = sda_oe_q;
    so_d       = so_q;
    wr_d       = 1'h0;
    host_begin = 1'h0;
    if (por_q) begin
      st_d     = DS_IDLE;
      sda_oe_d = 1'h0;
    end else if (spi_q) begin
      sda_oe_d = 1'h0;
      if (cs_n) begin
        st_d  = DS_IDLE;                                // RQ9
        cnt_d = '0;
      end else if (st_q == DS_IDLE) begin
        st_d  = DS_CMD;                                 // RQ13
        cnt_d = '0;
      end else if (scl_rise) begin
        cnt_d = (cnt_q == CNT_LAST) ? '0 : cnt_q + 4'h1;  // RQ7
        sh_d  = rx_byte;                                // RQ7
        if (cnt_q == CNT_LAST) begin
          unique case (st_q)
            DS_CMD: begin
              idx_d      = {1'h0, rx_byte[6:0]};        // RQ13
              rw_d       = rx_byte[CMD_RD_BIT];         // RQ13
              st_d       = rx_byte[CMD_RD_BIT] ? DS_READ : DS_WRITE;
              host_begin = 1'h1;
            end
            DS_WRITE: begin
              wr_d    = 1'h1;                           // RQ8
              wdata_d = rx_byte;                        // RQ8
              idx_d   = idx_q + 8'h1;                   // RQ8
            end
            default: ;
          endcase
        end
      end else if (scl_fall && st_q == DS_READ) begin
        if (cnt_q == '0) begin
          tx_d  = reg_rdata;                            // RQ9
          so_d  = reg_rdata[7];                         // RQ7
          idx_d = idx_q + 8'h1;                         // RQ9
        end else begin
          tx_d = {tx_q[6:0], 1'h0};
          so_d = tx_q[6];                               // RQ7
        end
      end
    end else begin
      if (sda_fall && s2_q[P_SCL]) begin
        st_d     = DS_ADDR;                             // RQ5
        cnt_d    = '0;
        sda_oe_d = 1'h0;
      end else if (sda_rise && s2_q[P_SCL]) begin
        st_d     = DS_IDLE;                             // RQ4
        sda_oe_d = 1'h0;
      end else if (st_q != DS_IDLE) begin
        if (scl_rise) begin
          if (cnt_q < CNT_ACK) begin
            sh_d  = rx_byte;
            cnt_d = cnt_q + 4'h1;
          end else if (cnt_q == CNT_ACK) begin
            ack_d = sda_in;                             // RQ5
            cnt_d = CNT_ACK_END;
          end
        end else if (scl_fall) begin
          if (cnt_q == CNT_ACK) begin
            sda_oe_d = 1'h1;                            // RQ4
            unique case (st_q)
              DS_ADDR: begin
                if (sh_q[7:1] == my_addr) begin         // RQ6
                  rw_d       = sh_q[0];
                  host_begin = 1'h1;
                end else begin
                  st_d     = DS_IDLE;
                  sda_oe_d = 1'h0;
                end
              end
              DS_INDEX: idx_d = sh_q;                   // RQ4
              DS_WRITE: begin
                wr_d    = 1'h1;                         // RQ4
                wdata_d = sh_q;                         // RQ4
                idx_d   = idx_q + 8'h1;                 // RQ4
              end
              default: sda_oe_d = 1'h0;                 // RQ5
            endcase
          end else if (cnt_q == CNT_ACK_END) begin
            cnt_d    = '0;
            sda_oe_d = 1'h0;
            if ((st_q == DS_ADDR && rw_q) || (st_q == DS_READ && !ack_q)) begin
              st_d     = DS_READ;                       // RQ5
              tx_d     = reg_rdata;                     // RQ5
              sda_oe_d = ~reg_rdata[7];
              idx_d    = idx_q + 8'h1;                  // RQ5
            end else if (st_q == DS_READ) begin
              st_d = DS_IDLE;                           // RQ5
            end else if (st_q == DS_ADDR) begin
              st_d = DS_INDEX;                          // RQ4
            end else begin
              st_d = DS_WRITE;                          // RQ4
            end
          end else if (st_q == DS_READ) begin
            tx_d     = {tx_q[6:0], 1'h0};
            sda_oe_d = ~tx_q[6];                        // RQ5
          end
        end
      end
    end
    so_oe_d = spi_q & ~cs_n & ~por_q & (st_d == DS_READ);  // RQ14
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q     <= DS_IDLE;
      cnt_q    <= '0;
      sh_q     <= '0;
      tx_q     <= '0;
      idx_q    <= '0;
      wdata_q  <= '0;
      rw_q     <= 1'h0;
      ack_q    <= 1'h1;
      sda_oe_q <= 1'h0;
      so_q     <= 1'h0;
      so_oe_q  <= 1'h0;
      wr_q     <= 1'h0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      tx_q     <= tx_d;
      idx_q    <= idx_d;
      wdata_q  <= wdata_d;
      rw_q     <= rw_d;
      ack_q    <= ack_d;
      sda_oe_q <= sda_oe_d;
      so_q     <= so_d;
      so_oe_q  <= so_oe_d;
      wr_q     <= wr_d;
    end
  end

  // ==========================================================
  // outputs
  assign link.sda_d_oe             = sda_oe_q;
  assign link.so_o                 = so_q;
  assign link.so_oe                = so_oe_q;
  assign link.measurement_done_irq = irq_q;
  assign reg_addr                  = idx_q;
  assign reg_wdata                 = wdata_q;
  assign reg_wr                    = wr_q;
  assign core_rst                  = por_q;
  assign spi_mode                  = spi_q;
  assign touch_o                   = touch_q;
  assign touch_oe                  = touch_oe_q;
  assign error_o                   = err_q;
  assign error_oe                  = touch_oe_q;
endmodule : tsp_dev_port

// ---- rtl/tsp_pkg.sv ----
// shared constants and state types for the touch sensor serial port
package tsp_pkg;
  localparam int          DW                  = 8;
  localparam int          CLK_PERIOD_NS       = 8;
  // i2c 7-bit addresses chosen by the strap level
  localparam logic [6:0]  ADDR_STRAP_LOW      = 7'h16;
  localparam logic [6:0]  ADDR_STRAP_HIGH     = 7'h17;
  // spi command byte: read flag in the top bit, start index below it
  localparam int          CMD_RD_BIT          = 7;
  // bit counter marks inside one i2c or spi byte
  localparam logic [3:0]  CNT_ACK             = 4'h8;
  localparam logic [3:0]  CNT_ACK_END         = 4'h9;
  localparam logic [3:0]  CNT_LAST            = 4'h7;
  // synchroniser lane positions on the device side
  localparam int          P_SCL               = 0;
  localparam int          P_SDA               = 1;
  localparam int          P_CS                = 2;
  localparam int          P_STRAP             = 3;
  localparam int          P_XRST              = 4;
  localparam int          NPIN                = 5;
  // power-on reset interval
  localparam int          POR_RELEASE_TIME_NS = 100000;
  localparam int          POR_CYCLES          = (POR_RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // host serial clock timing, least periods
  localparam int          I2C_PERIOD_NS       = 2500;
  localparam int          I2C_QTR_CYCLES      = (I2C_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SPI_PERIOD_NS       = 200;
  localparam int          SPI_HALF_CYCLES     = (SPI_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_INDEX, DS_WRITE, DS_READ, DS_CMD
  } tsp_dev_st_t;

  typedef enum logic [3:0] {
    HS_IDLE, HS_START, HS_ADDR, HS_INDEX, HS_WDATA, HS_RESTART, HS_ADDRR,
    HS_RDATA, HS_STOP, HS_SPI_CMD, HS_SPI_DATA, HS_SPI_END
  } tsp_host_st_t;
endpackage : tsp_pkg

// ---- rtl/tsp_link_if.sv ----
// serial pins between the host and the touch sensor port
`timescale 1ns/1ns
interface tsp_link_if;
  logic scl;
  logic chip_select_n;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_oe;
  logic so_o;
  logic so_oe;
  logic measurement_done_irq;
  logic address_select_pin;
  logic sda;
  logic strap_so;

  // sda is open drain from the device, push-pull or open drain from the host
  assign sda      = (sda_h_oe ? sda_h_o : 1'h1) & ~sda_d_oe;
  // shared pin: address strap in i2c, data out in spi
  assign strap_so = so_oe ? so_o : address_select_pin;

  modport dev  (input scl, chip_select_n, sda, strap_so,
                output sda_d_oe, so_o, so_oe, measurement_done_irq);
  modport host (output scl, chip_select_n, sda_h_o, sda_h_oe,
                input sda, strap_so, measurement_done_irq);
endinterface : tsp_link_if

// ---- rtl/tsp_host_port.sv ----
// host end: i2c and spi burst master for the touch sensor port
`timescale 1ns/1ns
module tsp_host_port
  import tsp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  tsp_link_if.host           link,
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire logic          cmd_spi,
  input  wire logic          cmd_mode3,
  input  wire logic          cmd_addr_high,
  input  wire logic          cmd_read,
  input  wire logic [7:0]    cmd_index,
  input  wire logic [7:0]    cmd_len,
  input  wire logic [DW-1:0] wr_data,
  output logic               wr_take,
  output logic      [DW-1:0] rd_data,
  output logic               rd_valid,
  output logic               done,
  output logic               nack,
  output logic               irq
);
  // ==========================================================
  // pin synchronisers: sda, so, irq
  logic [2:0] s1_q, s2_q;
  always_ff @(posedge clk) begin
    s1_q <= {link.measurement_done_irq, link.strap_so, link.sda};
    s2_q <= s1_q;
  end

  // ==========================================================
  // sequencer
  tsp_host_st_t st_q, st_d;
  logic [7:0]  div_q, div_d, sh_q, sh_d, len_q, len_d, rdd_q, rdd_d, index_q, index_d;
  logic [1:0]  ph_q, ph_d;
  logic [3:0]  bit_q, bit_d;
  logic [6:0]  addr_q, addr_d;
  logic        rd_q, rd_d, m3_q, m3_d, scl_q, scl_d, sdo_q, sdo_d, sdoe_q, sdoe_d;
  logic        cs_q, cs_d, take_q, take_d, rdv_q, rdv_d, done_q, done_d;
  logic        nack_q, nack_d, rdy_q, rdy_d, tick, is_tx, last;

  assign tick  = (div_q == '0) & ~rdy_q;
  assign is_tx = (st_q == HS_ADDR) | (st_q == HS_INDEX) | (st_q == HS_WDATA) | (st_q == HS_ADDRR);
  assign last  = (len_q == 8'h1);

  always_comb begin
    st_d = st_q; div_d = div_q; sh_d = sh_q; len_d = len_q; rdd_d = rdd_q;
    ph_d = ph_q; bit_d = bit_q; addr_d = addr_q; rd_d = rd_q; m3_d = m3_q;
    scl_d = scl_q; sdo_d = sdo_q; sdoe_d = sdoe_q; cs_d = cs_q; nack_d = nack_q;
    rdy_d = rdy_q; take_d = 1'h0; rdv_d = 1'h0; done_d = 1'h0;
    index_d = index_q;
    if (!rdy_q) begin
      div_d = tick ? 8'((cs_q ? I2C_QTR_CYCLES : SPI_HALF_CYCLES) - 1) : div_q - 8'h1;
    end
    if (rdy_q && cmd_valid) begin
      rdy_d  = 1'h0;
      ph_d   = '0;
      bit_d  = '0;
      rd_d   = cmd_read;
      len_d  = cmd_len;
      m3_d   = cmd_mode3;
      nack_d = 1'h0;
      index_d = cmd_index;
      addr_d = cmd_addr_high ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
      div_d  = '0;
      if (cmd_spi) begin
        cs_d   = 1'h0;                                  // RQ10
        // keep sck at its idle level for a half period after select falls
        div_d  = 8'(SPI_HALF_CYCLES - 1);
        scl_d  = cmd_mode3;                             // RQ7
        sdoe_d = 1'h1;
        sh_d   = {cmd_read, cmd_index[6:0]};            // RQ13
        st_d   = HS_SPI_CMD;
      end else begin
        sdo_d = 1'h0;
        sh_d  = cmd_index;
        st_d  = HS_START;
      end
    end else if (tick) begin
      ph_d = ph_q + 2'h1;
      unique case (st_q)
        HS_START, HS_RESTART: begin
          unique case (ph_q)
            2'h0: sdoe_d = 1'h0;
            2'h1: scl_d  = 1'h1;
            2'h2: sdoe_d = 1'h1;                        // RQ5
            2'h3: begin
              scl_d = 1'h0;
              sh_d  = {addr_q, st_q == HS_RESTART};     // RQ5
              st_d  = (st_q == HS_RESTART) ? HS_ADDRR : HS_ADDR;
            end
          endcase
          if (st_q == HS_START && ph_q == 2'h3) sh_d = {addr_q, 1'h0};  // RQ4
        end
        HS_STOP: begin
          unique case (ph_q)
            2'h0: sdoe_d = 1'h1;
            2'h1: scl_d  = 1'h1;
            2'h2: sdoe_d = 1'h0;                        // RQ4
            2'h3: begin
              st_d   = HS_IDLE;
              rdy_d  = 1'h1;
              done_d = 1'h1;
            end
          endcase
        end
        HS_ADDR, HS_INDEX, HS_WDATA, HS_ADDRR, HS_RDATA: begin
          unique case (ph_q)
            2'h0: begin
              if (bit_q < CNT_ACK) sdoe_d = is_tx & ~sh_q[7];
              else sdoe_d = ~is_tx & ~last;             // RQ5
            end
            2'h1: scl_d = 1'h1;
            2'h2: begin
              if (bit_q < CNT_ACK) sh_d = {sh_q[6:0], s2_q[0]};
              else if (is_tx) nack_d = nack_q | s2_q[0];
            end
            2'h3: begin
              scl_d = 1'h0;
              bit_d = bit_q + 4'h1;
              if (bit_q == CNT_ACK) begin
                bit_d = '0;
                unique case (st_q)
                  HS_ADDR: begin
                    st_d = nack_q ? HS_STOP : HS_INDEX;
                    // the shifter now holds the echoed address, reload the index
                    sh_d = index_q;                     // RQ4
                  end
                  HS_ADDRR: st_d = nack_q ? HS_STOP : HS_RDATA;
                  HS_INDEX: begin
                    st_d = nack_q ? HS_STOP : (rd_q ? HS_RESTART : HS_WDATA);
                    sh_d = wr_data;
                    take_d = ~rd_q & ~nack_q;
                  end
                  HS_WDATA: begin
                    len_d  = len_q - 8'h1;              // RQ4
                    st_d   = (last || nack_q) ? HS_STOP : HS_WDATA;
                    sh_d   = wr_data;
                    take_d = ~last & ~nack_q;
                  end
                  default: begin
                    rdd_d = sh_q;                       // RQ5
                    rdv_d = 1'h1;
                    len_d = len_q - 8'h1;
                    st_d  = last ? HS_STOP : HS_RDATA;  // RQ5
                  end
                endcase
              end
            end
          endcase
        end
        HS_SPI_CMD, HS_SPI_DATA: begin
          ph_d = {1'h0, ~ph_q[0]};
          if (!ph_q[0]) begin
            scl_d = 1'h0;
            sdo_d = sh_q[7];                            // RQ13
          end else begin
            scl_d = 1'h1;                               // RQ7
            sh_d  = {sh_q[6:0], s2_q[1]};               // RQ7
            bit_d = bit_q + 4'h1;
            if (bit_q == CNT_LAST) begin
              bit_d = '0;
              st_d  = HS_SPI_DATA;
              if (st_q == HS_SPI_DATA) begin
                len_d = len_q - 8'h1;
                if (last) st_d = HS_SPI_END;            // RQ8
                if (rd_q) begin
                  rdd_d = {sh_q[6:0], s2_q[1]};         // RQ9
                  rdv_d = 1'h1;
                end
              end
              if (!rd_q && !(st_q == HS_SPI_DATA && last)) begin
                sh_d   = wr_data;                       // RQ8
                take_d = 1'h1;
              end
            end
          end
        end
        HS_SPI_END: begin
          cs_d   = 1'h1;                                // RQ9
          scl_d  = m3_q;
          sdoe_d = 1'h0;
          st_d   = HS_IDLE;
          rdy_d  = 1'h1;
          done_d = 1'h1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= HS_IDLE; div_q <= '0; sh_q <= '0; len_q <= '0; rdd_q <= '0;
      ph_q <= '0; bit_q <= '0; addr_q <= '0; rd_q <= 1'h0; m3_q <= 1'h0;
      scl_q <= 1'h1; sdo_q <= 1'h0; sdoe_q <= 1'h0; cs_q <= 1'h1;
      take_q <= 1'h0; rdv_q <= 1'h0; done_q <= 1'h0; nack_q <= 1'h0; rdy_q <= 1'h1;
      index_q <= '0;
    end else begin
      st_q <= st_d; div_q <= div_d; sh_q <= sh_d; len_q <= len_d; rdd_q <= rdd_d;
      ph_q <= ph_d; bit_q <= bit_d; addr_q <= addr_d; rd_q <= rd_d; m3_q <= m3_d;
      scl_q <= scl_d; sdo_q <= sdo_d; sdoe_q <= sdoe_d; cs_q <= cs_d;
      take_q <= take_d; rdv_q <= rdv_d; done_q <= done_d; nack_q <= nack_d; rdy_q <= rdy_d;
      index_q <= index_d;
    end
  end

  assign link.scl           = scl_q;
  assign link.chip_select_n = cs_q;
  assign link.sda_h_o       = sdo_q;
  assign link.sda_h_oe      = sdoe_q;
  assign cmd_ready          = rdy_q;
  assign wr_take            = take_q;
  assign rd_data            = rdd_q;
  assign rd_valid           = rdv_q;
  assign done               = done_q;
  assign nack               = nack_q;
  assign irq                = s2_q[2];
endmodule : tsp_host_port

// ---- tb/tsp_link_monitor.sv ----
// assertions on the serial link between host and device ends
`timescale 1ns/1ns
module tsp_link_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic chip_select_n,
  input wire logic sda_d_oe,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic measurement_done_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // link checks
  irq_por_a: assert property ($fell(rst) |-> measurement_done_irq)
    else $error("irq low in power-on reset");
  por_release_a: assert property ($fell(rst) |->
    measurement_done_irq [*8] ##[8:40] !measurement_done_irq) else $error("reset not released");
  so_hiz_a: assert property (chip_select_n [*4] |-> !so_oe)
    else $error("so driven while deselected");
  spi_no_ack_a: assert property (!chip_select_n [*4] |-> !sda_d_oe)
    else $error("sda pulled while selected");
  ack_edge_a: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("sda moved while scl high");
  so_edge_a: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !scl)
    else $error("so moved while sck high");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high too short");
  scl_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low too short");
  cover property ($rose(sda_d_oe));
  cover property ($rose(so_oe));
  cover property ($fell(chip_select_n));
endmodule : tsp_link_monitor

// ---- tb/tb.sv ----
// bench: host and device ends joined over the serial link
`timescale 1ns/1ns
module tb;
  import tsp_pkg::*;
  logic clk = 0, rst = 1, external_reset_n = 1, meas_done = 0, strap = 0, error_in = 0;
  logic cmd_valid = 0, cmd_spi = 0, cmd_mode3 = 0, cmd_addr_high = 0, cmd_read = 0;
  logic [7:0] cmd_index = 0, cmd_len = 1, wr_data = 0, touch_in = 0, reg_addr, reg_wdata, reg_rdata, rd_data;
  logic cmd_ready, wr_take, rd_valid, done, nack, irq, reg_wr, core_rst, spi_mode, touch_oe, error_o, error_oe;
  logic [7:0] touch_o;
  logic [8:0] pin_q = 0;
  logic por_p = 1, rst_p = 1;
  logic [7:0] mem [256], em [256], bq [$], rq [$];
  logic [15:0] wq [$];
  int fails = 0, checked = 0, seed = 1388, k;
  always #4 clk = ~clk;
  tsp_link_if i_tsp_link_if ();
  assign i_tsp_link_if.address_select_pin = strap;
  assign reg_rdata = mem[reg_addr];
  tsp_dev_port #(.POR_CYC(20)) i_tsp_dev_port (.link(i_tsp_link_if.dev), .*);
  tsp_host_port i_tsp_host_port (.link(i_tsp_link_if.host), .*);
  tsp_link_monitor i_tsp_link_monitor (.clk(clk), .rst(rst), .scl(i_tsp_link_if.scl),
    .chip_select_n(i_tsp_link_if.chip_select_n), .sda_d_oe(i_tsp_link_if.sda_d_oe),
    .so_o(i_tsp_link_if.so_o), .so_oe(i_tsp_link_if.so_oe),
    .measurement_done_irq(i_tsp_link_if.measurement_done_irq));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task wait_por;
    k = 0;
    while (core_rst !== 1'b0 && k < 99) begin @(negedge clk); k++; end
    if (k == 99) begin fails++; print_verdict; end
  endtask : wait_por
  task automatic run(input logic s, m, h, r, input logic [7:0] i, n, input logic ack);
    for (int j = 0; j < n; j++) begin
      if (r && ack) rq.push_back(em[8'(i + j)]);
      if (!r) bq.push_back(8'($random(seed)));
      if (!r && ack) begin
        wq.push_back({8'(i + j), bq[j]});
        em[8'(i + j)] = bq[j];
      end
    end
    repeat (10) @(posedge clk);
    k = 0;
    while (cmd_ready !== 1'b1 && k < 99) begin @(negedge clk); k++; end
    if (k >= 99) begin fails++; print_verdict; end
    @(posedge clk);
    {cmd_spi, cmd_mode3, cmd_addr_high, cmd_read, cmd_index, cmd_len} <= {s, m, h, r, i, n};
    wr_data <= r ? 8'h00 : bq[0];
    cmd_valid <= 1;
    @(posedge clk);
    cmd_valid <= 0;
    k = 0;
    do begin @(negedge clk); k++; end while (done !== 1'b1 && k < 40000);
    if (k >= 40000) begin fails++; print_verdict; end
    chk(nack, !ack);
    bq.delete();
    $display("test spi %0b read %0b index %h length %0d done", s, r, i, n);
  endtask : run
  always @(posedge clk) begin
    {error_in, touch_in} <= 9'($random(seed));
    rst_p <= rst;
    por_p <= core_rst;
    pin_q <= {error_in, touch_in};
    if (!rst_p) chk({error_o, touch_o}, por_p ? 9'h000 : pin_q);
    if (wr_take) begin
      void'(bq.pop_front());
      wr_data <= bq.size() > 0 ? bq[0] : 8'h00;
    end
    if (reg_wr) begin
      mem[reg_addr - 8'h01] <= reg_wdata;
      chk({reg_addr - 8'h01, reg_wdata}, wq.pop_front());
    end
    if (rd_valid) chk(rd_data, rq.pop_front());
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
      em[i] = 8'(i) ^ 8'h5A;
    end
    repeat (12) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk({core_rst, touch_oe, error_oe}, 3'h4);
    wait_por;
    chk({i_tsp_link_if.measurement_done_irq, touch_oe, error_oe}, 3'h3);
    @(posedge clk) meas_done <= 1;
    @(posedge clk) meas_done <= 0;
    repeat (4) @(negedge clk);
    chk(irq, 1'b1);
    run(0, 0, 0, 0, 8'h20, 3, 1);
    run(0, 0, 0, 1, 8'h20, 3, 1);
    run(0, 0, 1, 0, 8'h30, 1, 0);
    @(posedge clk) strap <= 1;
    run(0, 0, 1, 0, 8'h30, 2, 1);
    run(0, 0, 0, 1, 8'h30, 1, 0);
    run(0, 0, 1, 1, 8'h30, 1, 1);
    run(1, 0, 0, 0, 8'h50, 2, 1);
    chk(spi_mode, 1);
    run(1, 1, 0, 1, 8'h50, 3, 1);
    run(1, 1, 0, 0, 8'h60, 2, 1);
    run(1, 0, 0, 1, 8'h60, 2, 1);
    @(posedge clk) external_reset_n <= 0;
    repeat (6) @(negedge clk);
    chk({spi_mode, touch_oe, error_oe, core_rst}, 4'h1);
    @(posedge clk) external_reset_n <= 1;
    wait_por;
    run(0, 0, 1, 1, 8'h51, 2, 1);
    chk(16'(wq.size() + rq.size()), 16'h0000);
    print_verdict;
  end
endmodule : tb
